// >>> design/srh_map.vh
// Function
// R1: With pin 1 driver on, bit 0 drives low, bit 1 drives power-down.
// R2: Read/write bit, reset zero, enables the pin 0 input buffer.
// R3: Writing 1 to calibration start begins ratio calculation, readable at 0x0A.
// R4: Software clears calibration start before requesting another calculation.
// R5: Slot B hold bit set freezes slot B data registers.
// R6: Slot A hold bit set freezes slot A data registers.
// R7: Software sets hold while reading so four channels stay coherent.
// R8: Clock enable bit turns fast clock on; software clears it afterwards.
// R9: Sample rate is 32 kHz over four times divider, reset 0x0028.
// R10: Slot B averaging field, reset 6, picks samples summed and averaged.
// R11: Sums land at 0x70-0x7F, averages at 0x64-0x6B and buffer 0x60.
// R12: Slot B output rate divided by the averaging factor.
// R13: Averaging codes above 1 use factor two to the code, up to 128.
`ifndef SRH_MAP_VH
`define SRH_MAP_VH
`define SRH_A_CLK_RATIO 8'h0A
`define SRH_A_RATE_DIV 8'h12
`define SRH_A_AVG_CFG 8'h15
`define SRH_A_PIN_CFG 8'h4F
`define SRH_A_PIN1_CAL 8'h50
`define SRH_A_HOLD_CLK 8'h5F
`define SRH_A_BUFFER 8'h60
`define SRH_A_AVG_BASE 8'h64
`define SRH_A_SUM_BASE 8'h70
`define SRH_R_RATE_DIV 16'h0028
`define SRH_R_AVG_CFG 16'h0600
`define SRH_R_PIN_CFG 16'h2090
`define SRH_R_ZERO 16'h0000
`define SRH_B_PIN0_IE 1
`define SRH_B_PIN1_OE 6
`define SRH_B_PIN1_SRC 6
`define SRH_B_CAL_START 5
`define SRH_B_FAST_CLK 0
`define SRH_B_HOLD_A 1
`define SRH_B_HOLD_B 2
`define SRH_F_AVG_HI 10
`define SRH_F_AVG_LO 8
`define SRH_A_AVG_B_BASE 8'h68
`define SRH_A_SUM_B_BASE 8'h78
`define SRH_N_AVG_WORDS 8'h04
`define SRH_N_SUM_WORDS 8'h08
`define SRH_SLOW_PER_STEP 18'h00004
`endif

// >>> design/srh_avg.v
`timescale 1ns/1ps
`include "srh_map.vh"
module srh_avg #(
	parameter W = 16,
	parameter CH = 4,
	parameter SW = 32
) (
	input wire core_clk,
	input wire rst_b,
	input wire in_valid,
	input wire [CH*W-1:0] in_data,
	input wire [2:0] code,
	output reg out_valid_q,
	output reg [CH*SW-1:0] sum_q,
	output reg [CH*W-1:0] avg_q
);

	// ---------------------------------------------
	// Accumulate 2**code samples per channel
	// ---------------------------------------------
	reg [CH*SW-1:0] acc_q;
	reg [7:0] cnt_q;
	reg [CH*SW-1:0] acc_n;
	reg [SW-1:0] s;
	reg [SW-1:0] sh;
	reg [CH*W-1:0] avg_n;
	integer i;

	function [7:0] avg_factor;
		input [2:0] c;
		begin
			avg_factor = 8'h01 << c; // R13
		end
	endfunction

	always @*
	begin
		acc_n = acc_q;
		avg_n = {CH*W{1'b0}};
		s = {SW{1'b0}};
		sh = {SW{1'b0}};
		for (i = 0; i < CH; i = i + 1)
		begin
			s = acc_q[i*SW +: SW] + {{(SW-W){1'b0}}, in_data[i*W +: W]};
			acc_n[i*SW +: SW] = s;
			sh = s >> code;
			avg_n[i*W +: W] = sh[W-1:0];
		end
	end

	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			acc_q <= {CH*SW{1'b0}};
			cnt_q <= 8'h00;
			out_valid_q <= 1'b0;
			sum_q <= {CH*SW{1'b0}};
			avg_q <= {CH*W{1'b0}};
		end
		else
		begin
			out_valid_q <= 1'b0;
			if (in_valid)
			begin
				if (cnt_q + 8'h01 >= avg_factor(code)) // R10
				begin
					// One result per group of summed samples
					acc_q <= {CH*SW{1'b0}}; // R12
					cnt_q <= 8'h00;
					out_valid_q <= 1'b1;
					sum_q <= acc_n;
					avg_q <= avg_n;
				end
				else
				begin
					acc_q <= acc_n;
					cnt_q <= cnt_q + 8'h01;
				end
			end
		end
	end

endmodule

// >>> design/srh_regs.v
`timescale 1ns/1ps
`include "srh_map.vh"
module srh_regs #(
	parameter W = 16,
	parameter CH = 4,
	parameter RATIO_W = 12
) (
	input wire core_clk,
	input wire rst_b,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata_q,
	input wire slow_tick,
	output reg sample_tick_q,
	input wire slot_a_valid,
	input wire [CH*W-1:0] slot_a_data,
	input wire slot_b_valid,
	input wire [CH*W-1:0] slot_b_data,
	output reg slot_b_result_q,
	input wire analog_front_end_pd,
	output reg general_pin_one_o_q,
	output reg general_pin_one_oe_b_q,
	input wire general_pin_zero_i,
	output reg pin0_input_q,
	output reg fast_clock_cal_start_q,
	output reg fast_clock_enable_q,
	input wire ratio_valid,
	input wire [RATIO_W-1:0] ratio_in
);

	localparam SW = 32;

	// ---------------------------------------------
	// Register storage
	// ---------------------------------------------
	reg [15:0] rate_div_q;
	reg [15:0] avg_cfg_q;
	reg [15:0] pin_cfg_q;
	reg [15:0] pin1_cal_q;
	reg [15:0] hold_clk_q;
	reg [RATIO_W-1:0] ratio_q;
	reg [CH*W-1:0] avg_a_q;
	reg [CH*W-1:0] avg_b_q;
	reg [CH*SW-1:0] sum_a_q;
	reg [CH*SW-1:0] sum_b_q;
	reg [15:0] buffer_q;
	reg pin0_s1_q;
	reg pin0_s2_q;
	reg [17:0] tick_cnt_q;
	wire b_valid;
	wire [CH*SW-1:0] b_sum;
	wire [CH*W-1:0] b_avg;
	wire wr_hit_cal;
	wire wr_rate;
	wire wr_avg;
	wire wr_pin;
	wire wr_hold;
	wire [17:0] step_limit;
	wire [2:0] avg_code;

	// ---------------------------------------------
	// Address decode helpers
	// ---------------------------------------------
	function wr_to;
		input [7:0] a;
		input [7:0] target;
		input wr;
		begin
			wr_to = wr && (a == target);
		end
	endfunction

	function in_win;
		input [7:0] a;
		input [7:0] base;
		input [7:0] count;
		begin
			in_win = (a >= base) && (a < base + count);
		end
	endfunction

	// ---------------------------------------------
	// Write strobes and decoded fields
	// ---------------------------------------------
	assign avg_code = avg_cfg_q[`SRH_F_AVG_HI:`SRH_F_AVG_LO];
	assign wr_hit_cal = wr_to(reg_addr, `SRH_A_PIN1_CAL, reg_wr);
	assign wr_rate = wr_to(reg_addr, `SRH_A_RATE_DIV, reg_wr);
	assign wr_avg = wr_to(reg_addr, `SRH_A_AVG_CFG, reg_wr);
	assign wr_pin = wr_to(reg_addr, `SRH_A_PIN_CFG, reg_wr);
	assign wr_hold = wr_to(reg_addr, `SRH_A_HOLD_CLK, reg_wr);
	assign step_limit = {2'b00, rate_div_q} * `SRH_SLOW_PER_STEP; // R9

	// Whole-word writes, reserved bits keep what was written
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			rate_div_q <= `SRH_R_RATE_DIV; // R9
			avg_cfg_q <= `SRH_R_AVG_CFG; // R10
			pin_cfg_q <= `SRH_R_PIN_CFG; // R2
			pin1_cal_q <= `SRH_R_ZERO;
			hold_clk_q <= `SRH_R_ZERO;
		end
		else
		begin
			if (wr_rate)
				rate_div_q <= reg_wdata;
			if (wr_avg)
				avg_cfg_q <= reg_wdata;
			if (wr_pin)
				pin_cfg_q <= reg_wdata;
			if (wr_hit_cal)
				pin1_cal_q <= reg_wdata;
			if (wr_hold)
				hold_clk_q <= reg_wdata;
		end
	end

	// ---------------------------------------------
	// Fast clock calibration
	// ---------------------------------------------
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			fast_clock_cal_start_q <= 1'b0;
			fast_clock_enable_q <= 1'b0;
		end
		else
		begin
			// Start only on a 0 to 1 change, so a held 1 starts nothing
			fast_clock_cal_start_q <= wr_hit_cal && reg_wdata[`SRH_B_CAL_START]
				&& !pin1_cal_q[`SRH_B_CAL_START]; // R3 R4
			fast_clock_enable_q <= hold_clk_q[`SRH_B_FAST_CLK]; // R8
		end
	end

	// Last ratio delivered by the calibration logic
	always @(posedge core_clk)
	begin
		if (!rst_b)
			ratio_q <= {RATIO_W{1'b0}};
		else if (ratio_valid)
			ratio_q <= ratio_in; // R3
	end

	// ---------------------------------------------
	// General pin 1 output
	// ---------------------------------------------
	// Level only matters while the enable is low
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			general_pin_one_o_q <= 1'b0;
			general_pin_one_oe_b_q <= 1'b1;
		end
		else
		begin
			general_pin_one_o_q <= pin1_cal_q[`SRH_B_PIN1_SRC] & analog_front_end_pd; // R1
			general_pin_one_oe_b_q <= !pin_cfg_q[`SRH_B_PIN1_OE]; // R1
		end
	end

	// ---------------------------------------------
	// General pin 0 input, two-stage synchroniser
	// ---------------------------------------------
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			pin0_s1_q <= 1'b0;
			pin0_s2_q <= 1'b0;
			pin0_input_q <= 1'b0;
		end
		else
		begin
			pin0_s1_q <= general_pin_zero_i;
			pin0_s2_q <= pin0_s1_q;
			pin0_input_q <= pin0_s2_q & pin_cfg_q[`SRH_B_PIN0_IE]; // R2
		end
	end

	// ---------------------------------------------
	// Sample rate: slow ticks over four times divider
	// ---------------------------------------------
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			tick_cnt_q <= 18'h00000;
			sample_tick_q <= 1'b0;
		end
		else
		begin
			sample_tick_q <= 1'b0;
			if (slow_tick)
			begin
				// A new divider takes effect at the next slow tick, even mid-count
				if (tick_cnt_q + 18'h00001 >= step_limit) // R9
				begin
					tick_cnt_q <= 18'h00000;
					sample_tick_q <= 1'b1;
				end
				else
					tick_cnt_q <= tick_cnt_q + 18'h00001;
			end
		end
	end

	// ---------------------------------------------
	// Slot B averaging
	// ---------------------------------------------
	// Group length follows the code at each sample
	srh_avg #(
		.W(W),
		.CH(CH),
		.SW(SW)
	) u_avg (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_valid(slot_b_valid),
		.in_data(slot_b_data),
		.code(avg_code),
		.out_valid_q(b_valid),
		.sum_q(b_sum),
		.avg_q(b_avg)
	);

	// ---------------------------------------------
	// Result registers with per-slot hold
	// ---------------------------------------------
	integer i;
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			avg_a_q <= {CH*W{1'b0}};
			sum_a_q <= {CH*SW{1'b0}};
		end
		else if (slot_a_valid && !hold_clk_q[`SRH_B_HOLD_A]) // R6
		begin
			avg_a_q <= slot_a_data;
			for (i = 0; i < CH; i = i + 1)
				sum_a_q[i*SW +: SW] <= {{(SW-W){1'b0}}, slot_a_data[i*W +: W]};
		end
	end

	// Slot B data only moves on a group end with hold clear; the result strobe ignores hold
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			avg_b_q <= {CH*W{1'b0}};
			sum_b_q <= {CH*SW{1'b0}};
			buffer_q <= `SRH_R_ZERO;
			slot_b_result_q <= 1'b0;
		end
		else
		begin
			slot_b_result_q <= b_valid; // R12
			if (b_valid && !hold_clk_q[`SRH_B_HOLD_B]) // R5
			begin
				avg_b_q <= b_avg; // R11
				sum_b_q <= b_sum; // R11
				buffer_q <= b_avg[W-1:0]; // R11
			end
		end
	end

	// ---------------------------------------------
	// Read port, unmapped reads give zero
	// ---------------------------------------------
	reg [15:0] rd_n;
	// Result windows by address, anything past them reads zero
	always @*
	begin
		rd_n = `SRH_R_ZERO;
		case (reg_addr)
			`SRH_A_CLK_RATIO: rd_n = {{(16-RATIO_W){1'b0}}, ratio_q};
			`SRH_A_RATE_DIV: rd_n = rate_div_q;
			`SRH_A_AVG_CFG: rd_n = avg_cfg_q;
			`SRH_A_PIN_CFG: rd_n = pin_cfg_q;
			`SRH_A_PIN1_CAL: rd_n = pin1_cal_q;
			`SRH_A_HOLD_CLK: rd_n = hold_clk_q;
			`SRH_A_BUFFER: rd_n = buffer_q;
			default:
			begin
				if (in_win(reg_addr, `SRH_A_AVG_BASE, `SRH_N_AVG_WORDS))
					rd_n = avg_a_q[(reg_addr - `SRH_A_AVG_BASE) * W +: W]; // R11
				else if (in_win(reg_addr, `SRH_A_AVG_B_BASE, `SRH_N_AVG_WORDS))
					rd_n = avg_b_q[(reg_addr - `SRH_A_AVG_B_BASE) * W +: W]; // R11
				else if (in_win(reg_addr, `SRH_A_SUM_BASE, `SRH_N_SUM_WORDS))
					rd_n = sum_a_q[(reg_addr - `SRH_A_SUM_BASE) * W +: W]; // R11
				else if (in_win(reg_addr, `SRH_A_SUM_B_BASE, `SRH_N_SUM_WORDS))
					rd_n = sum_b_q[(reg_addr - `SRH_A_SUM_B_BASE) * W +: W]; // R11
			end
		endcase
	end

	always @(posedge core_clk)
	begin
		if (!rst_b)
			reg_rdata_q <= `SRH_R_ZERO;
		else if (reg_rd)
			reg_rdata_q <= rd_n;
	end

endmodule

// >>> verification/srh_checker.sv
`timescale 1ns/1ps
module srh_checker (
	input wire core_clk,
	input wire rst_b,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata_q,
	input wire slot_b_valid,
	input wire slot_b_result_q,
	input wire analog_front_end_pd,
	input wire general_pin_one_o_q,
	input wire general_pin_one_oe_b_q,
	input wire fast_clock_cal_start_q,
	input wire fast_clock_enable_q
);
	reg oe_q;
	reg src_q;
	reg cal_q;
	reg [15:0] hc_q;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Shadow copies of written control bits
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		oe_q <= rst_b & (reg_wr && reg_addr == 8'h4F ? reg_wdata[6] : oe_q);
		src_q <= rst_b & (reg_wr && reg_addr == 8'h50 ? reg_wdata[6] : src_q);
		cal_q <= rst_b & (reg_wr && reg_addr == 8'h50 ? reg_wdata[5] : cal_q);
		hc_q <= {16{rst_b}} & (reg_wr && reg_addr == 8'h5F ? reg_wdata : hc_q);
	end
	sequence wr50;
		reg_wr && reg_addr == 8'h50;
	endsequence
	sequence wr5f;
		reg_wr && reg_addr == 8'h5F;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	chk_pin_drive: assert property (general_pin_one_o_q == $past(src_q & analog_front_end_pd))
		else $error("pin 1 level wrong");
	chk_pin_enable: assert property (general_pin_one_oe_b_q == !$past(oe_q))
		else $error("pin 1 enable wrong");
	chk_cal_start: assert property (wr50 ##0 reg_wdata[5] && !cal_q |=> fast_clock_cal_start_q)
		else $error("calibration start missing");
	chk_cal_cause: assert property (fast_clock_cal_start_q |-> $past(reg_wr && reg_addr == 8'h50 && reg_wdata[5] && !cal_q))
		else $error("calibration start without cause");
	chk_clk_enable: assert property (wr5f |=> ##1 fast_clock_enable_q == $past(reg_wdata[0], 2))
		else $error("fast clock enable wrong");
	chk_hold_read: assert property (reg_rd && reg_addr == 8'h5F |=> reg_rdata_q == $past(hc_q))
		else $error("hold register readback wrong");
	chk_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data moved");
	chk_result_cause: assert property (slot_b_result_q |-> $past(slot_b_valid, 2))
		else $error("result without sample");
endmodule
bind srh_regs srh_checker i_srh_checker (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q),
	.slot_b_valid(slot_b_valid),
	.slot_b_result_q(slot_b_result_q),
	.analog_front_end_pd(analog_front_end_pd),
	.general_pin_one_o_q(general_pin_one_o_q),
	.general_pin_one_oe_b_q(general_pin_one_oe_b_q),
	.fast_clock_cal_start_q(fast_clock_cal_start_q),
	.fast_clock_enable_q(fast_clock_enable_q)
);

// >>> verification/srh_regs_bench.sv
`timescale 1ns/1ps
module srh_regs_bench;
	reg core_clk, rst_b, wr, rd, slow, av, bv, pd, pz, rv, b;
	reg [7:0] ad;
	reg [15:0] wd, num_errors, total_checks, n_st, n_cs, n_br, b0;
	reg [63:0] adat, bdat;
	reg [11:0] rat;
	reg [31:0] s, e;
	reg [3:0] c;
	wire [15:0] rdq;
	wire stq, brq, o, oeb, piq, csq, feq;
	srh_regs i_srh_regs (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(ad), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdq), .slow_tick(slow), .sample_tick_q(stq),
		.slot_a_valid(av), .slot_a_data(adat), .slot_b_valid(bv), .slot_b_data(bdat),
		.slot_b_result_q(brq), .analog_front_end_pd(pd), .general_pin_one_o_q(o),
		.general_pin_one_oe_b_q(oeb), .general_pin_zero_i(pz), .pin0_input_q(piq),
		.fast_clock_cal_start_q(csq), .fast_clock_enable_q(feq), .ratio_valid(rv), .ratio_in(rat));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			n_st <= 16'h0000;
			n_cs <= 16'h0000;
			n_br <= 16'h0000;
		end
		else
		begin
			n_st <= n_st + stq;
			n_cs <= n_cs + csq;
			n_br <= n_br + brq;
		end
	end
	function [31:0] exp_avg(input [31:0] sum, input [3:0] code);
		exp_avg = sum >> code;
	endfunction
	function exp_pin1(input src, input pd_in);
		exp_pin1 = src & pd_in;
	endfunction
	task cmp(input [15:0] g, input [15:0] x);
	begin
		total_checks = total_checks + 1;
		if (g !== x)
		begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	end
	endtask
	task tk(input integer n);
		repeat (n) @(negedge core_clk);
	endtask
	task wr_reg(input [7:0] a, input [15:0] d);
	begin
		tk(1);
		ad = a;
		wd = d;
		wr = 1;
		tk(1);
		wr = 0;
	end
	endtask
	task rd_reg(input [7:0] a, input [15:0] x);
	begin
		tk(1);
		ad = a;
		rd = 1;
		tk(1);
		rd = 0;
		cmp(rdq, x);
	end
	endtask
	task close_out;
	begin
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	initial
	begin
		{core_clk, rst_b, wr, rd, slow, av, bv, pd, pz, rv, ad, wd, adat, bdat, rat} = 0;
		{num_errors, total_checks} = 0;
		void'($urandom(32'h7E7D));
		tk(17);
		rst_b = 1;
		rd_reg(8'h12, 16'h0028);
		rd_reg(8'h15, 16'h0600);
		rd_reg(8'h4F, 16'h2090);
		rd_reg(8'h50, 16'h0000);
		rd_reg(8'h5F, 16'h0000);
		rd_reg(8'h33, 16'h0000);
		wr_reg(8'h12, 16'h0002);
		repeat (16)
		begin
			slow = 1;
			tk(1);
			slow = 0;
			tk(1);
		end
		tk(3);
		cmp(n_st, 16'h0002);
		pz = 1;
		tk(4);
		cmp(piq, 16'h0000);
		wr_reg(8'h4F, 16'h2092);
		tk(4);
		cmp(piq, 16'h0001);
		cmp(oeb, 16'h0001);
		pz = 0;
		tk(4);
		cmp(piq, 16'h0000);
		wr_reg(8'h4F, 16'h20D0);
		tk(2);
		cmp(oeb, 16'h0000);
		repeat (8)
		begin
			pd = $urandom;
			b = $urandom;
			wr_reg(8'h50, {9'h000, b, 6'h00});
			tk(2);
			cmp(o, exp_pin1(b, pd));
		end
		wr_reg(8'h50, 16'h0020);
		wr_reg(8'h50, 16'h0020);
		tk(2);
		cmp(n_cs, 16'h0001);
		wr_reg(8'h50, 16'h0000);
		wr_reg(8'h50, 16'h0020);
		tk(2);
		cmp(n_cs, 16'h0002);
		rat = $urandom;
		rv = 1;
		tk(1);
		rv = 0;
		rd_reg(8'h0A, {4'h0, rat});
		wr_reg(8'h5F, 16'h0001);
		tk(1);
		cmp(feq, 16'h0001);
		wr_reg(8'h5F, 16'h0000);
		tk(1);
		cmp(feq, 16'h0000);
		adat = {$urandom, $urandom};
		av = 1;
		tk(1);
		av = 0;
		e = adat[15:0];
		wr_reg(8'h5F, 16'h0002);
		adat = ~adat;
		av = 1;
		tk(1);
		av = 0;
		tk(3);
		rd_reg(8'h64, e[15:0]);
		wr_reg(8'h5F, 16'h0000);
		for (c = 0; c < 8; c = c + 1)
		begin
			wr_reg(8'h15, {5'h00, c[2:0], 8'h00});
			s = 0;
			b0 = n_br;
			repeat (1 << c)
			begin
				bdat = {$urandom, $urandom};
				s = s + bdat[15:0];
				bv = 1;
				tk(1);
			end
			bv = 0;
			tk(3);
			e = exp_avg(s, c);
			cmp(n_br - b0, 16'h0001);
			rd_reg(8'h68, e[15:0]);
			rd_reg(8'h60, e[15:0]);
			rd_reg(8'h78, s[15:0]);
			rd_reg(8'h79, s[31:16]);
		end
		wr_reg(8'h5F, 16'h0004);
		wr_reg(8'h15, 16'h0000);
		bdat = ~bdat;
		bv = 1;
		tk(1);
		bv = 0;
		tk(3);
		rd_reg(8'h68, e[15:0]);
		rd_reg(8'h5F, 16'h0004);
		close_out;
	end
	initial
	begin
		#100000;
		num_errors = num_errors + 1;
		close_out;
	end
endmodule
